/* rtl/crap_pkg.sv */
// Shared constants for the calibration, reset and alarm-pin control block.
// Assumes an 8-bit register space reached by a simple strobed access port.
package crap_pkg;
  // Register offsets
  localparam logic [7:0] REG_CAL_CTRL    = 8'h88;
  localparam logic [7:0] REG_SKEW2       = 8'h8F;
  localparam logic [7:0] REG_PIN_CTRL    = 8'h90;
  localparam logic [7:0] REG_ALARM_FLAGS = 8'h91;
  localparam logic [7:0] REG_ALARM_MASK  = 8'h92;
  localparam logic [7:0] REG_STATUS      = 8'h93;
  localparam logic [7:0] REG_DIVIDER     = 8'h94;

  // Field positions
  localparam int CAL_START_BIT       = 6;
  localparam int PIN_IRQ_SELECT_BIT  = 0;
  localparam int PIN_IRQ_POL_BIT     = 1;
  localparam int PIN_IN1_EN_BIT      = 2;
  localparam int PIN_IN2_EN_BIT      = 3;
  localparam int PIN_FAULT_POL_BIT   = 4;
  localparam int PIN_OFFSET_INCLUDE_BIT = 5;
  localparam int FLAG_LOS1_BIT       = 0;
  localparam int FLAG_LOS2_BIT       = 1;
  localparam int FLAG_FOS1_BIT       = 2;
  localparam int FLAG_FOS2_BIT       = 3;
  localparam int FLAG_LOCK_LOSS_BIT  = 4;
  localparam int NUM_FLAGS           = 5;
  localparam int STAT_CAL_BUSY_BIT   = 0;
  localparam int STAT_CALIBRATED_BIT = 1;
  localparam int STAT_LOCK_LOSS_BIT  = 2;
  localparam int STAT_PROGRAMMED_BIT = 3;

  // Reset values
  localparam logic [7:0] SKEW2_RESET    = 8'h00;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET     = 8'h00;
  localparam logic [7:0] DIVIDER_RESET  = 8'h00;

  // Timing
  localparam int CLK_PERIOD_PS       = 25000;
  localparam int DEV_RST_HOLD_NS     = 100;
  localparam int DEV_RST_HOLD_CYCLES =
    ((DEV_RST_HOLD_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    CRAP_H_IDLE,
    CRAP_H_READ_WAIT,
    CRAP_H_RESET_HOLD
  } crap_host_state_e;
endpackage : crap_pkg

/* rtl/crap_if.sv */
// Link between the host controller and the clock-multiplier control logic.
// Fault pins are output-only tri-state pins; the bench resolves them from oe_n.
`timescale 1ns/1ps
interface crap_if;
  logic       rst_n;              // Active-low hardware reset pin
  logic       wr;                 // Register write strobe
  logic       rd;                 // Register read strobe
  logic [7:0] addr;               // Register offset
  logic [7:0] wdata;              // Write data
  logic [7:0] rdata;              // Read data
  logic       rvalid;             // Read data valid pulse
  logic       irq_or_input1_fault_pin_o;
  logic       irq_or_input1_fault_pin_oe_n;
  logic       input2_fault_pin_o;
  logic       input2_fault_pin_oe_n;

  modport dev (
    input  rst_n, wr, rd, addr, wdata,
    output rdata, rvalid,
    output irq_or_input1_fault_pin_o, irq_or_input1_fault_pin_oe_n,
    output input2_fault_pin_o, input2_fault_pin_oe_n
  );
  modport host (
    output rst_n, wr, rd, addr, wdata,
    input  rdata, rvalid,
    input  irq_or_input1_fault_pin_o, irq_or_input1_fault_pin_oe_n,
    input  input2_fault_pin_o, input2_fault_pin_oe_n
  );
endinterface : crap_if

/* rtl/crap_device.sv */
// Control logic of the clock multiplier: skew register, calibration
// trigger, hardware reset and the two alarm/interrupt pins.
// Assumes alarm inputs are synchronous to i_core_clk.
`timescale 1ns/1ps
module crap_device
  import crap_pkg::*;
(
  input  wire logic       i_core_clk,        // 40 MHz clock
  input  wire logic       i_sys_rst,         // Async reset, active high
  input  wire logic       i_clk_en,          // Freezes all state when low
  crap_if.dev             bus,               // Host link
  input  wire logic       i_los1,            // Input-one signal loss alarm
  input  wire logic       i_los2,            // Input-two signal loss alarm
  input  wire logic       i_fos1,            // Input-one frequency offset alarm
  input  wire logic       i_fos2,            // Input-two frequency offset alarm
  input  wire logic       i_lock_loss,       // Lock-loss alarm from the PLL
  output logic            o_cal_start,       // One-cycle calibration start pulse
  output logic            o_clk_out_enable,  // Clock outputs enabled
  output logic [7:0]      o_skew2,           // Output-two phase skew
  output logic [7:0]      o_divider          // Sensitive divider setting
);
  logic [7:0]           output2_phase_skew_q;
  logic [7:0]           pin_ctrl_q;
  logic [7:0]           mask_q;
  logic [7:0]           divider_q;
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] alarm_now;
  logic                 cal_busy_q;
  logic                 calibrated_q;
  logic                 programmed_q;
  logic                 lock_loss_q;
  logic                 soft_rst;
  logic                 wr_en;
  logic                 cal_write;
  logic                 irq_level;
  logic                 fault1;
  logic                 fault2;
  logic [7:0]           rdata_d;

  // Reset pin is sampled synchronously; it acts as a clocked clear
  assign soft_rst  = ~bus.rst_n;
  assign wr_en     = bus.wr & ~soft_rst;
  assign cal_write = wr_en & (bus.addr == REG_CAL_CTRL) & bus.wdata[CAL_START_BIT];

  assign alarm_now[FLAG_LOS1_BIT] = i_los1;
  assign alarm_now[FLAG_LOS2_BIT] = i_los2;
  assign alarm_now[FLAG_FOS1_BIT] = i_fos1;
  assign alarm_now[FLAG_FOS2_BIT] = i_fos2;
  assign alarm_now[FLAG_LOCK_LOSS_BIT] = i_lock_loss;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      output2_phase_skew_q <= SKEW2_RESET;
    end else if (i_clk_en) begin
      if (soft_rst) begin
        output2_phase_skew_q <= SKEW2_RESET;
      end else if (wr_en && bus.addr == REG_SKEW2) begin
        output2_phase_skew_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_ctrl_q <= PIN_CTRL_RESET;
      mask_q     <= MASK_RESET;
      divider_q  <= DIVIDER_RESET;
    end else if (i_clk_en) begin
      if (soft_rst) begin
        pin_ctrl_q <= PIN_CTRL_RESET;
        mask_q     <= MASK_RESET;
        divider_q  <= DIVIDER_RESET;
      end else if (wr_en) begin
        if (bus.addr == REG_PIN_CTRL) begin
          pin_ctrl_q <= bus.wdata;
        end
        if (bus.addr == REG_ALARM_MASK) begin
          mask_q <= bus.wdata;
        end
        if (bus.addr == REG_DIVIDER) begin
          divider_q <= bus.wdata;
        end
      end
    end
  end

  // Sticky alarm flags, write one to clear; a live alarm wins over the clear
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
      always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          flags_q[g] <= 1'b0;
        end else if (i_clk_en) begin
          if (soft_rst) begin
            flags_q[g] <= 1'b0;
          end else if (alarm_now[g]) begin
            flags_q[g] <= 1'b1;
          end else if (wr_en && bus.addr == REG_ALARM_FLAGS && bus.wdata[g]) begin
            flags_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Calibration: start pulse, then busy until lock loss falls low
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cal_start  <= 1'b0;
      cal_busy_q   <= 1'b0;
      calibrated_q <= 1'b0;
      lock_loss_q  <= 1'b1;
    end else if (i_clk_en) begin
      lock_loss_q <= i_lock_loss;
      if (soft_rst) begin
        o_cal_start  <= 1'b0;
        cal_busy_q   <= 1'b0;
        calibrated_q <= 1'b0;
      end else begin
        o_cal_start <= cal_write;
        if (cal_write) begin
          cal_busy_q   <= 1'b1;
          calibrated_q <= 1'b0;
        end else if (cal_busy_q && !o_cal_start && lock_loss_q && !i_lock_loss) begin
          cal_busy_q   <= 1'b0;
          calibrated_q <= 1'b1;
        end
      end
    end
  end

  // Any register write since reset counts as programming
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      programmed_q <= 1'b0;
    end else if (i_clk_en) begin
      if (soft_rst) begin
        programmed_q <= 1'b0;
      end else if (wr_en) begin
        programmed_q <= 1'b1;
      end
    end
  end

  // Clock output enable only after programming and a finished calibration; skew and divider outputs follow their registers
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_clk_out_enable <= 1'b0;
      o_skew2          <= SKEW2_RESET;
      o_divider        <= DIVIDER_RESET;
    end else if (i_clk_en) begin
      o_clk_out_enable <= ~soft_rst & programmed_q & calibrated_q & ~cal_busy_q;
      o_skew2          <= output2_phase_skew_q;
      o_divider        <= divider_q;
    end
  end

  // Register reads: one cycle to rvalid; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (bus.addr)
      REG_CAL_CTRL:    rdata_d = 8'h00;
      REG_SKEW2:       rdata_d = output2_phase_skew_q;
      REG_PIN_CTRL:    rdata_d = pin_ctrl_q;
      REG_ALARM_FLAGS: rdata_d = {{(8-NUM_FLAGS){1'b0}}, flags_q};
      REG_ALARM_MASK:  rdata_d = mask_q;
      REG_DIVIDER:     rdata_d = divider_q;
      REG_STATUS: begin
        rdata_d[STAT_CAL_BUSY_BIT]   = cal_busy_q;
        rdata_d[STAT_CALIBRATED_BIT] = calibrated_q;
        rdata_d[STAT_LOCK_LOSS_BIT]  = lock_loss_q;
        rdata_d[STAT_PROGRAMMED_BIT] = programmed_q;
      end
      default:         rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus.rdata  <= 8'h00;
      bus.rvalid <= 1'b0;
    end else if (i_clk_en) begin
      bus.rvalid <= bus.rd & ~soft_rst;
      bus.rdata  <= (bus.rd & ~soft_rst) ? rdata_d : 8'h00;
    end
  end

  // Alarm pin levels
  assign irq_level = |(flags_q & mask_q[NUM_FLAGS-1:0]);
  assign fault1 = i_los1 | (pin_ctrl_q[PIN_OFFSET_INCLUDE_BIT] & i_fos1);
  assign fault2 = i_los2 | (pin_ctrl_q[PIN_OFFSET_INCLUDE_BIT] & i_fos2);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus.irq_or_input1_fault_pin_o    <= 1'b0;
      bus.irq_or_input1_fault_pin_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      if (soft_rst) begin
        bus.irq_or_input1_fault_pin_o    <= 1'b0;
        bus.irq_or_input1_fault_pin_oe_n <= 1'b1;
      end else if (pin_ctrl_q[PIN_IRQ_SELECT_BIT]) begin
        // Polarity bit set means active high
        bus.irq_or_input1_fault_pin_o    <= ~(irq_level ^ pin_ctrl_q[PIN_IRQ_POL_BIT]);
        bus.irq_or_input1_fault_pin_oe_n <= 1'b0;
      end else if (pin_ctrl_q[PIN_IN1_EN_BIT]) begin
        bus.irq_or_input1_fault_pin_o    <= fault1 ^ pin_ctrl_q[PIN_FAULT_POL_BIT];
        bus.irq_or_input1_fault_pin_oe_n <= 1'b0;
      end else begin
        bus.irq_or_input1_fault_pin_o    <= 1'b0;
        bus.irq_or_input1_fault_pin_oe_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus.input2_fault_pin_o    <= 1'b0;
      bus.input2_fault_pin_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      if (!soft_rst && pin_ctrl_q[PIN_IN2_EN_BIT]) begin
        bus.input2_fault_pin_o    <= fault2 ^ pin_ctrl_q[PIN_FAULT_POL_BIT];
        bus.input2_fault_pin_oe_n <= 1'b0;
      end else begin
        bus.input2_fault_pin_o    <= 1'b0;
        bus.input2_fault_pin_oe_n <= 1'b1;
      end
    end
  end
endmodule : crap_device

/* rtl/crap_host.sv */
// Host controller end: register access, device reset and calibration policy.
// Assumes the user tells it when configuration is complete and the clock is stable.
`timescale 1ns/1ps
module crap_host
  import crap_pkg::*;
#(
  parameter int RST_HOLD_CYCLES = DEV_RST_HOLD_CYCLES
)(
  input  wire logic       i_core_clk,       // 40 MHz clock
  input  wire logic       i_sys_rst,        // Async reset, active high
  input  wire logic       i_clk_en,         // Freezes all state when low
  crap_if.host            bus,              // Device link
  input  wire logic       i_cmd_valid,      // Register command request
  input  wire logic       i_cmd_write,      // 1 write, 0 read
  input  wire logic [7:0] i_cmd_addr,       // Register offset
  input  wire logic [7:0] i_cmd_data,       // Write data
  input  wire logic       i_cal_req,        // Request calibration
  input  wire logic       i_clk_stable,     // Selected input clock stable
  input  wire logic       i_config_done,    // Configuration complete pulse
  input  wire logic       i_dev_reset_req,  // Request device hardware reset
  output logic            o_cmd_ready,      // Idle, can take a command
  output logic [7:0]      o_rd_data,        // Read result
  output logic            o_rd_valid,       // Read result pulse
  output logic            o_need_program,   // Device must be programmed
  output logic            o_recal_needed,   // Sensitive setting changed
  output logic            o_cal_refused     // Calibration request refused pulse
);
  crap_host_state_e state_q;
  logic [15:0]      hold_cnt_q;
  logic             calibrated_q;
  logic             idle;
  logic             do_cmd;
  logic             do_cal;
  logic             sensitive;

  assign idle      = (state_q == CRAP_H_IDLE);
  assign do_cal    = idle & i_cal_req & ~i_dev_reset_req & ~o_need_program
                     & i_clk_stable;
  assign do_cmd    = idle & i_cmd_valid & ~i_cal_req & ~i_dev_reset_req;
  assign sensitive = (i_cmd_addr == REG_DIVIDER);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q    <= CRAP_H_RESET_HOLD;
      hold_cnt_q <= 16'h0000;
      bus.rst_n  <= 1'b0;
    end else if (i_clk_en) begin
      case (state_q)
        CRAP_H_IDLE: begin
          if (i_dev_reset_req) begin
            state_q    <= CRAP_H_RESET_HOLD;
            hold_cnt_q <= 16'h0000;
            bus.rst_n  <= 1'b0;
          end else if (do_cmd && !i_cmd_write) begin
            state_q <= CRAP_H_READ_WAIT;
          end
        end
        CRAP_H_READ_WAIT: begin
          if (bus.rvalid) begin
            state_q <= CRAP_H_IDLE;
          end
        end
        CRAP_H_RESET_HOLD: begin
          if (hold_cnt_q >= 16'(RST_HOLD_CYCLES - 1)) begin
            state_q   <= CRAP_H_IDLE;
            bus.rst_n <= 1'b1;
          end else begin
            hold_cnt_q <= hold_cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q   <= CRAP_H_IDLE;
          bus.rst_n <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= 8'h00;
      bus.wdata <= 8'h00;
    end else if (i_clk_en) begin
      bus.wr <= do_cal | (do_cmd & i_cmd_write);
      bus.rd <= do_cmd & ~i_cmd_write;
      if (do_cal) begin
        bus.addr  <= REG_CAL_CTRL;
        bus.wdata <= 8'(1 << CAL_START_BIT);
      end else if (do_cmd) begin
        bus.addr  <= i_cmd_addr;
        bus.wdata <= i_cmd_data;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_need_program <= 1'b1;
      o_recal_needed <= 1'b0;
      calibrated_q   <= 1'b0;
      o_cal_refused  <= 1'b0;
    end else if (i_clk_en) begin
      o_cal_refused <= idle & i_cal_req & ~i_dev_reset_req & ~do_cal;
      if (state_q == CRAP_H_RESET_HOLD) begin
        o_need_program <= 1'b1;
        o_recal_needed <= 1'b0;
        calibrated_q   <= 1'b0;
      end else begin
        if (i_config_done) begin
          o_need_program <= 1'b0;
        end
        if (do_cal) begin
          calibrated_q   <= 1'b1;
          o_recal_needed <= 1'b0;
        end else if (do_cmd && i_cmd_write && sensitive && calibrated_q) begin
          o_recal_needed <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cmd_ready <= 1'b0;
      o_rd_data   <= 8'h00;
      o_rd_valid  <= 1'b0;
    end else if (i_clk_en) begin
      o_cmd_ready <= (state_q == CRAP_H_IDLE) & ~do_cmd & ~do_cal & ~i_dev_reset_req;
      o_rd_valid  <= (state_q == CRAP_H_READ_WAIT) & bus.rvalid;
      if (bus.rvalid) begin
        o_rd_data <= bus.rdata;
      end
    end
  end
endmodule : crap_host

/* verification/crap_checker.sv */
// Concurrent checks on the link between host controller and clock-multiplier control logic.
// Assumes the clock enable of both ends is high while the link is busy; signals are plain inputs.
`timescale 1ns/1ps
module crap_checker
  import crap_pkg::*;
(
  input wire logic       i_core_clk,                   // 40 MHz clock
  input wire logic       i_sys_rst,                    // Async reset, active high
  input wire logic       rst_n,                        // Device reset pin, active low
  input wire logic       wr,                           // Write strobe
  input wire logic       rd,                           // Read strobe
  input wire logic [7:0] addr,                         // Register offset
  input wire logic [7:0] wdata,                        // Write data
  input wire logic [7:0] rdata,                        // Read data
  input wire logic       rvalid,                       // Read data valid
  input wire logic       irq_or_input1_fault_pin_o,    // Pin one value
  input wire logic       irq_or_input1_fault_pin_oe_n, // Pin one enable, low drives
  input wire logic       input2_fault_pin_o,           // Pin two value
  input wire logic       input2_fault_pin_oe_n         // Pin two enable, low drives
);
  logic [7:0] skew_q;
  logic [7:0] ctrl_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // Shadows obey the reset pin too, so a device reset in mid-run stays coherent
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) skew_q <= SKEW2_RESET;
    else if (!rst_n) skew_q <= SKEW2_RESET;
    else if (wr && addr == REG_SKEW2) skew_q <= wdata;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) ctrl_q <= PIN_CTRL_RESET;
    else if (!rst_n) ctrl_q <= PIN_CTRL_RESET;
    else if (wr && addr == REG_PIN_CTRL) ctrl_q <= wdata;
  end

  sequence s_read(logic [7:0] a);
    rd && rst_n && addr == a;
  endsequence

  chk_read_answer: assert property (rd && rst_n |=> rvalid)
    else $error("read strobe got no answer");
  chk_rvalid_cause: assert property (rvalid |-> $past(rd && rst_n))
    else $error("read answer without an accepted read");
  chk_rdata_idle: assert property (!rvalid |-> rdata == 8'h00)
    else $error("read data not zero outside an answer");
  chk_skew_readback: assert property (s_read(REG_SKEW2) |=> rdata == $past(skew_q))
    else $error("skew register read back wrong");
  chk_cal_self_clear: assert property (s_read(REG_CAL_CTRL) |=> !rdata[CAL_START_BIT])
    else $error("calibration start bit did not clear");
  chk_reset_quiet: assert property (!rst_n |=> irq_or_input1_fault_pin_oe_n
      && input2_fault_pin_oe_n && !rvalid)
    else $error("device not quiet while reset pin low");
  chk_pin1_float: assert property (!(ctrl_q[0] | ctrl_q[2]) && !$past(ctrl_q[0] | ctrl_q[2])
      |-> irq_or_input1_fault_pin_oe_n && !irq_or_input1_fault_pin_o)
    else $error("pin one driven with no function selected");
  chk_pin2_float: assert property (!ctrl_q[3] && !$past(ctrl_q[3])
      |-> input2_fault_pin_oe_n && !input2_fault_pin_o)
    else $error("pin two driven while disabled");
  chk_pin1_drive: assert property ((ctrl_q[0] | ctrl_q[2]) && $past(ctrl_q[0] | ctrl_q[2])
      && $past(rst_n) |-> !irq_or_input1_fault_pin_oe_n)
    else $error("pin one floats with a function selected");
  chk_pin2_drive: assert property (ctrl_q[3] && $past(ctrl_q[3]) && $past(rst_n)
      |-> !input2_fault_pin_oe_n)
    else $error("pin two floats while enabled");
endmodule : crap_checker

/* verification/calibration_reset_alarm_pins_test.sv */
// Self-checking bench: host and device ends joined by the link, user sides driven here.
// Assumes a 40 MHz clock and inputs driven a fixed delay after the rising edge.
`timescale 1ns/1ps
module calibration_reset_alarm_pins_test;
  import crap_pkg::*;
  localparam time TD = 2ns;
  logic       clk, rst, cmd_valid, cmd_write, cal_req, clk_stable, config_done, dev_reset_req;
  logic [7:0] cmd_addr, cmd_data, rd_data, skew2, divider, d;
  logic       los1, los2, fos1, fos2, lock_loss, cmd_ready, rd_valid, need_program;
  logic       recal_needed, cal_refused, cal_start, clk_out_en, clk_en;
  int         fail_count, tests_run, start_n, refused_n;
  // Row: ctrl, mask, alarms {los1,los2,fos1,fos2}, pins {oe1_n,o1,oe2_n,o2}
  localparam logic [23:0] PIN_TAB [12] = '{
    24'h00_00_F_A, 24'h04_00_8_6, 24'h14_00_8_2, 24'h04_00_2_2, 24'h24_00_2_6, 24'h08_00_4_9,
    24'h18_00_4_8, 24'h28_00_1_9, 24'h03_01_8_6, 24'h01_01_8_2, 24'h07_02_8_2, 24'h01_01_0_6};

  crap_if bus_if();
  crap_device crap_device_i(.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .bus(bus_if),
    .i_los1(los1), .i_los2(los2), .i_fos1(fos1), .i_fos2(fos2), .i_lock_loss(lock_loss),
    .o_cal_start(cal_start), .o_clk_out_enable(clk_out_en), .o_skew2(skew2), .o_divider(divider));
  crap_host #(.RST_HOLD_CYCLES(4)) crap_host_i(.i_core_clk(clk), .i_sys_rst(rst),
    .i_clk_en(clk_en), .bus(bus_if), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write),
    .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data), .i_cal_req(cal_req),
    .i_clk_stable(clk_stable), .i_config_done(config_done), .i_dev_reset_req(dev_reset_req),
    .o_cmd_ready(cmd_ready), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_need_program(need_program), .o_recal_needed(recal_needed), .o_cal_refused(cal_refused));
  crap_checker crap_checker_i(.i_core_clk(clk), .i_sys_rst(rst), .rst_n(bus_if.rst_n),
    .wr(bus_if.wr), .rd(bus_if.rd), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .rvalid(bus_if.rvalid),
    .irq_or_input1_fault_pin_o(bus_if.irq_or_input1_fault_pin_o),
    .irq_or_input1_fault_pin_oe_n(bus_if.irq_or_input1_fault_pin_oe_n),
    .input2_fault_pin_o(bus_if.input2_fault_pin_o),
    .input2_fault_pin_oe_n(bus_if.input2_fault_pin_oe_n));

  initial begin
    clk = 1'b0;
    forever #12.5ns clk = ~clk;
  end

  // Pulses are counted here so no scenario has to guess their exact edge
  always @(posedge clk) begin
    if (cal_start === 1'b1) start_n++;
    if (cal_refused === 1'b1) refused_n++;
  end

  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #TD;
  endtask : tick

  task automatic host_cmd(input logic w, input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    {cmd_valid, cmd_write, cmd_addr, cmd_data} = {1'b1, w, a, v};
    tick(1);
    cmd_valid = 1'b0;
    tick(1);
  endtask : host_cmd

  task automatic host_read(input logic [7:0] a, output logic [7:0] v);
    int n;
    n = 0;
    host_cmd(1'b0, a, 8'h00);
    while (rd_valid !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (rd_valid !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    v = rd_data;
  endtask : host_read

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(3);
  endtask : pulse

  task automatic t_defaults();
    host_read(REG_SKEW2, d);
    cmp(d, SKEW2_RESET);
    cmp({7'h00, need_program}, 8'h01);
    cmp({7'h00, clk_out_en}, 8'h00);
    cmp({6'h00, bus_if.irq_or_input1_fault_pin_oe_n, bus_if.input2_fault_pin_oe_n}, 8'h03);
    pulse(cal_req);
    cmp(8'(refused_n), 8'h01);
  endtask : t_defaults

  task automatic t_skew();
    foreach (PIN_TAB[k]) begin
      if (k < 3) begin
        host_cmd(1'b1, REG_SKEW2, 8'h7F + 8'(k));
        host_read(REG_SKEW2, d);
        cmp(d, 8'h7F + 8'(k));
        cmp(skew2, 8'h7F + 8'(k));
      end
    end
    // A frozen host must ignore a reset request and the device keep its state
    clk_en = 1'b0;
    dev_reset_req = 1'b1;
    tick(8);
    dev_reset_req = 1'b0;
    clk_en = 1'b1;
    tick(2);
    cmp({7'h00, bus_if.rst_n}, 8'h01);
    cmp(skew2, 8'h81);
  endtask : t_skew

  task automatic t_calibrate();
    lock_loss = 1'b1;
    pulse(config_done);
    clk_stable = 1'b0;
    pulse(cal_req);
    cmp(8'(refused_n), 8'h02);
    clk_stable = 1'b1;
    pulse(cal_req);
    cmp(8'(start_n), 8'h01);
    host_read(REG_CAL_CTRL, d);
    cmp(d, 8'h00);
    host_read(REG_STATUS, d);
    cmp(d, 8'h0D);
    lock_loss = 1'b0;
    tick(3);
    host_read(REG_STATUS, d);
    cmp(d, 8'h0A);
    cmp({7'h00, clk_out_en}, 8'h01);
    host_cmd(1'b1, REG_DIVIDER, 8'h05);
    tick(1);
    cmp({7'h00, recal_needed}, 8'h01);
    cmp(divider, 8'h05);
  endtask : t_calibrate

  task automatic t_pins();
    foreach (PIN_TAB[k]) begin
      {los1, los2, fos1, fos2} = PIN_TAB[k][7:4];
      host_cmd(1'b1, REG_PIN_CTRL, PIN_TAB[k][23:16]);
      host_cmd(1'b1, REG_ALARM_MASK, PIN_TAB[k][15:8]);
      tick(3);
      cmp({4'h0, bus_if.irq_or_input1_fault_pin_oe_n, bus_if.irq_or_input1_fault_pin_o,
        bus_if.input2_fault_pin_oe_n, bus_if.input2_fault_pin_o},
        {4'h0, PIN_TAB[k][3:0]});
      {los1, los2, fos1, fos2} = 4'h0;
      tick(1);
      host_cmd(1'b1, REG_ALARM_FLAGS, 8'h1F);
    end
    // A live alarm must win over a clear of its flag
    los2 = 1'b1;
    host_cmd(1'b1, REG_ALARM_FLAGS, 8'h1F);
    host_read(REG_ALARM_FLAGS, d);
    cmp(d, 8'h02);
    los2 = 1'b0;
    tick(1);
    host_cmd(1'b1, REG_ALARM_FLAGS, 8'h1F);
    host_read(REG_ALARM_FLAGS, d);
    cmp(d, 8'h00);
  endtask : t_pins

  task automatic t_dev_reset();
    dev_reset_req = 1'b1;
    tick(1);
    dev_reset_req = 1'b0;
    tick(2);
    cmp({6'h00, bus_if.rst_n, clk_out_en}, 8'h00);
    host_read(REG_SKEW2, d);
    cmp(d, SKEW2_RESET);
    host_read(REG_PIN_CTRL, d);
    cmp(d, PIN_CTRL_RESET);
    cmp({6'h00, need_program, clk_out_en}, 8'h02);
    pulse(cal_req);
    cmp(8'(refused_n), 8'h03);
  endtask : t_dev_reset

  initial begin
    {rst, cmd_valid, cmd_write, cal_req, config_done, dev_reset_req} = 6'b100000;
    {cmd_addr, cmd_data, los1, los2, fos1, fos2, lock_loss} = '0;
    {clk_stable, clk_en} = 2'b11;
    {fail_count, tests_run, start_n, refused_n} = '0;
    tick(6);
    rst = 1'b0;
    tick(1);
    t_defaults();
    t_skew();
    t_calibrate();
    t_pins();
    t_dev_reset();
    print_verdict();
  end
endmodule : calibration_reset_alarm_pins_test
